/* rtl/fmc_top.v */
// fan mode decode and second configuration register
// assumes the serial engine presents each received data byte on wr_* with
// wr_lsb_edge pulsing at the rising clock edge of that byte's lsb
`include "fmc_defs.vh"
module fmc_top #(
  parameter W = 8
) (
  input  wire         clk,
  input  wire         reset,
  input  wire         wr_lsb_edge,
  input  wire [7:0]   wr_addr,
  input  wire [7:0]   wr_data,
  input  wire [7:0]   rd_addr,
  input  wire [W-1:0] duty_cycle_setting,
  input  wire [15:0]  target_speed_count,
  input  wire [15:0]  measured_speed_count,
  input  wire         speed_valid,
  input  wire [W-1:0] remote_duty,
  input  wire [W-1:0] local_duty,
  input  wire         supply_flag,
  input  wire         remote_over_temp_flag,
  input  wire         remote_sensor_fail,
  input  wire         por_done,
  output reg  [7:0]   rd_data_q,
  output reg          ack_q,
  output reg          soft_reset_q,
  output reg          smbalert_n_q,
  output reg  [W-1:0] fan_duty_q,
  output reg  [1:0]   fan_mode_q
);
  reg [7:0] cfg1_q;
  reg [7:0] cfg2_q;
  reg       por_seen_q;
  wire      sw_rst;
  wire      fan_mode_sel_hi;
  wire      fan_mode_sel_lo;
  wire      supply_flag_int_en;
  wire      remote_over_temp_int_en;
  wire      alert;
  wire [W-1:0] duty_w;
  // -----------------------------------------------------------------------
  // field views
  // -----------------------------------------------------------------------
  assign fan_mode_sel_hi         = cfg1_q[`FMC_CFG1_MODE_HI];
  assign fan_mode_sel_lo         = cfg1_q[`FMC_CFG1_MODE_LO];
  assign supply_flag_int_en      = cfg2_q[`FMC_CFG2_SUP_IE];
  assign remote_over_temp_int_en = cfg2_q[`FMC_CFG2_ROT_IE];
  // reset bit written: acts on the lsb edge itself
  assign sw_rst = wr_lsb_edge && (wr_addr == `FMC_ADDR_CFG2) &&
                  wr_data[`FMC_CFG2_SWRST];
  // gated interrupt sources onto alert
  assign alert = cfg1_q[`FMC_CFG1_INT_EN] &&
                 ((supply_flag_int_en && supply_flag) ||
                  (remote_over_temp_int_en &&
                   remote_over_temp_flag));
  // -----------------------------------------------------------------------
  // configuration registers
  // -----------------------------------------------------------------------
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      cfg1_q       <= `FMC_CFG1_RESET;
      cfg2_q       <= `FMC_CFG2_RESET;
      por_seen_q   <= 1'b0;
      soft_reset_q <= 1'b0;
      ack_q        <= 1'b0;
    end else begin
      soft_reset_q <= sw_rst;
      ack_q        <= wr_lsb_edge && !sw_rst;
      if (sw_rst) begin
        cfg1_q     <= `FMC_CFG1_RESET;
        cfg2_q     <= `FMC_CFG2_RESET;
        por_seen_q <= 1'b0;
      end else begin
        // sensor failure caught once power-on checks finish
        if (por_done && !por_seen_q) begin
          por_seen_q <= 1'b1;
          if (remote_sensor_fail)
            cfg2_q[`FMC_CFG2_ROT_IE] <= 1'b0;
        end
        if (wr_lsb_edge && wr_addr == `FMC_ADDR_CFG1)
          cfg1_q <= wr_data;
        if (wr_lsb_edge && wr_addr == `FMC_ADDR_CFG2)
          cfg2_q <= {1'b0, wr_data[`FMC_CFG2_SUP_IE],
                     wr_data[`FMC_CFG2_ROT_IE],
                     cfg2_q[4:0]}; // low bits keep their value
      end
    end
  end
  // -----------------------------------------------------------------------
  // duty selection
  // -----------------------------------------------------------------------
  fmc_duty_select #(
    .W (W)
  ) u_duty (
    .clk                  (clk),
    .reset                (reset),
    .mode                 ({fan_mode_sel_hi, fan_mode_sel_lo}),
    .start                (cfg1_q[`FMC_CFG1_START]),
    .duty_cycle_setting   (duty_cycle_setting),
    .remote_duty          (remote_duty),
    .local_duty           (local_duty),
    .target_speed_count   (target_speed_count),
    .measured_speed_count (measured_speed_count),
    .speed_valid          (speed_valid),
    .duty_q               (duty_w)
  );
  // outputs and read mux
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      rd_data_q    <= 8'h00;
      smbalert_n_q <= 1'b1;
      fan_duty_q   <= `FMC_DUTY_ZERO;
      fan_mode_q   <= `FMC_MODE_AUTO_REM;
    end else begin
      smbalert_n_q <= !alert;
      fan_duty_q   <= duty_w;
      fan_mode_q   <= {fan_mode_sel_hi, fan_mode_sel_lo};
      if (rd_addr == `FMC_ADDR_CFG1)
        rd_data_q <= cfg1_q;
      else if (rd_addr == `FMC_ADDR_CFG2)
        rd_data_q <= {1'b0, cfg2_q[6:0]};
      else
        rd_data_q <= 8'h00;
    end
  end
endmodule

/* rtl/fmc_defs.vh */
// constants for the fan mode and second configuration register block
// assumes a register write port already decoded from the serial bus engine
// Notes on behaviour
// - mode 11: drive fan with larger of remote and local duty demands
// - mode 10: duty follows remote temperature; selected after power-on
// - mode 00: output exactly the duty written by the host
// - mode 01: hold host target speed count by adjusting duty
// - writing 1 to config two bit 7 resets device; reads 0
// - reset acts at data lsb clock edge; that byte gets no acknowledge
// - bit 6 gates supply flag interrupt; resets to 0
// - bit 5 gates remote over-temperature interrupt
// - remote over-temp enable powers up 1 unless sensor failed at power-on
// - mode bits are config one bits 6 and 5, reset 1 and 0
// - start bit 0 allows only software duty mode
// - enabled interrupts are signalled on the alert pin
`ifndef FMC_DEFS_VH
`define FMC_DEFS_VH
// -------------------------------------------------------------------------
// register map
// -------------------------------------------------------------------------
`define FMC_ADDR_CFG1     8'h00
`define FMC_ADDR_CFG2     8'h01
`define FMC_CFG1_RESET    8'hD4
`define FMC_CFG2_RESET    8'h3D
// -------------------------------------------------------------------------
// field positions
// -------------------------------------------------------------------------
`define FMC_CFG1_START    0
`define FMC_CFG1_INT_EN   1
`define FMC_CFG1_MODE_LO  5
`define FMC_CFG1_MODE_HI  6
`define FMC_CFG2_ROT_IE   5
`define FMC_CFG2_SUP_IE   6
`define FMC_CFG2_SWRST    7
`define FMC_CFG2_LOW_MASK 8'h1F
// -------------------------------------------------------------------------
// fan mode codes {hi, lo}
// -------------------------------------------------------------------------
`define FMC_MODE_SW_DUTY  2'h0
`define FMC_MODE_SW_SPEED 2'h1
`define FMC_MODE_AUTO_REM 2'h2
`define FMC_MODE_MAX_CALC 2'h3
`define FMC_DUTY_ZERO     8'h00
`define FMC_SPEED_STEP    8'h01
`define FMC_DUTY_FULL     8'hFF
`endif

/* rtl/fmc_duty_select.v */
// selects the fan duty cycle from the active fan mode
// assumes temperature-derived demands and a speed measurement arrive ready
`include "fmc_defs.vh"
module fmc_duty_select #(
  parameter W = 8
) (
  input  wire         clk,
  input  wire         reset,
  input  wire [1:0]   mode,
  input  wire         start,
  input  wire [W-1:0] duty_cycle_setting,
  input  wire [W-1:0] remote_duty,
  input  wire [W-1:0] local_duty,
  input  wire [15:0]  target_speed_count,
  input  wire [15:0]  measured_speed_count,
  input  wire         speed_valid,
  output reg  [W-1:0] duty_q
);
  reg [W-1:0] loop_q;
  reg [W-1:0] loop_d;
  reg [W-1:0] duty_d;
  // -----------------------------------------------------------------------
  // speed loop: larger count means slower fan, so raise duty
  // -----------------------------------------------------------------------
  always @* begin
    loop_d = loop_q;
    if (speed_valid) begin
      if (measured_speed_count > target_speed_count &&
          loop_q != `FMC_DUTY_FULL)
        loop_d = loop_q + `FMC_SPEED_STEP;
      else if (measured_speed_count < target_speed_count &&
               loop_q != `FMC_DUTY_ZERO)
        loop_d = loop_q - `FMC_SPEED_STEP;
    end
  end
  // mode decode; without start only software duty runs
  always @* begin
    duty_d = duty_q;
    if (!start) begin
      if (mode == `FMC_MODE_SW_DUTY)
        duty_d = duty_cycle_setting;
    end else begin
      case (mode)
        `FMC_MODE_MAX_CALC: duty_d = (remote_duty > local_duty) ?
                                     remote_duty : local_duty;
        `FMC_MODE_AUTO_REM: duty_d = remote_duty;
        `FMC_MODE_SW_SPEED: duty_d = loop_q;
        default:            duty_d = duty_cycle_setting;
      endcase
    end
  end
  // registers
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      loop_q <= `FMC_DUTY_ZERO;
      duty_q <= `FMC_DUTY_ZERO;
    end else begin
      loop_q <= (start && mode == `FMC_MODE_SW_SPEED) ? loop_d : duty_q;
      duty_q <= duty_d;
    end
  end
endmodule

/* dv/fmc_top_monitor.sv */
// assertions on the ports of the fan mode and config two block
// assumes a bind to fmc_top, one clock, async active-high reset
module fmc_monitor #(parameter W = 8) (
  input wire logic         clk,
  input wire logic         reset,
  input wire logic         wr_lsb_edge,
  input wire logic [7:0]   wr_addr,
  input wire logic [7:0]   wr_data,
  input wire logic [7:0]   rd_addr,
  input wire logic [W-1:0] duty_cycle_setting,
  input wire logic         supply_flag,
  input wire logic         remote_over_temp_flag,
  input wire logic [7:0]   rd_data_q,
  input wire logic         ack_q,
  input wire logic         soft_reset_q,
  input wire logic         smbalert_n_q,
  input wire logic [W-1:0] fan_duty_q,
  input wire logic [1:0]   fan_mode_q
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // write of config two with the reset bit set
  wire rst_wr = wr_lsb_edge && wr_addr == 8'h01 && wr_data[7];
  chk_ack_write: assert property (wr_lsb_edge && !rst_wr |=> ack_q)
    else $error("write byte not acknowledged");
  chk_rst_noack: assert property (rst_wr |=> !ack_q && soft_reset_q)
    else $error("reset byte acknowledged or no reset");
  chk_ack_cause: assert property (ack_q |-> $past(wr_lsb_edge))
    else $error("acknowledge without a write");
  chk_rst_pulse: assert property (soft_reset_q |=> !soft_reset_q)
    else $error("reset pulse too long");
  chk_rst_mode: assert property (soft_reset_q |-> ##2 fan_mode_q == 2'h2)
    else $error("mode not restored by reset");
  chk_rst_reads0: assert property (rd_addr == 8'h01 |=> !rd_data_q[7])
    else $error("reset bit reads one");
  chk_alert_cause: assert property (!smbalert_n_q |->
    $past(supply_flag) || $past(remote_over_temp_flag))
    else $error("alert without a flag");
  chk_mode_write: assert property (wr_lsb_edge && wr_addr == 8'h00 |-> ##2
    fan_mode_q == $past(wr_data[6:5], 2))
    else $error("mode bits not taken");
  chk_sw_duty: assert property (fan_mode_q == 2'h0 [*4] |->
    fan_duty_q == $past(duty_cycle_setting, 2))
    else $error("duty differs from host setting");
endmodule
bind fmc_top fmc_monitor #(.W(W)) i_mon (.clk, .reset, .wr_lsb_edge,
  .wr_addr, .wr_data, .rd_addr, .duty_cycle_setting, .supply_flag,
  .remote_over_temp_flag, .rd_data_q, .ack_q, .soft_reset_q, .smbalert_n_q,
  .fan_duty_q, .fan_mode_q);

/* dv/fmc_host.sv */
// bus host stand-in: register writes and reads, host duty and target
// assumes the bench calls its tasks from one process
module fmc_host (
  input wire logic    clk,
  input wire logic    ack_q,
  input wire logic [7:0] rd_data_q,
  output logic        wr_lsb_edge = 1'h0,
  output logic [7:0]  wr_addr = 8'h00,
  output logic [7:0]  wr_data = 8'h00,
  output logic [7:0]  rd_addr = 8'h00,
  output logic [7:0]  duty_cycle_setting = 8'h00,
  output logic [15:0] target_speed_count = 16'h0000
);
  timeunit 1ns;
  timeprecision 1ns;
  // one data byte; ack looked at just after the taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    output logic [7:0] k);
    @(posedge clk);
    wr_lsb_edge <= 1'h1;
    wr_addr <= a;
    wr_data <= d;
    @(posedge clk);
    wr_lsb_edge <= 1'h0;
    wr_addr <= ~a; // released lines show no stale value
    wr_data <= ~d;
    #1 k = {7'h00, ack_q};
  endtask
  // read one register
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    rd_addr <= a;
    @(posedge clk);
    #1 v = rd_data_q;
  endtask
  // host duty and speed target settings
  task automatic vals(input logic [7:0] d, input logic [15:0] t);
    @(posedge clk);
    duty_cycle_setting <= d;
    target_speed_count <= t;
  endtask
endmodule

/* dv/fmc_top_bench.sv */
// self-checking bench for the fan mode and config two block
// assumes the monitor is bound in and the host model drives the bus
module fmc_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, reset = 1, speed_valid = 0, supply_flag = 0;
  logic remote_over_temp_flag = 0, remote_sensor_fail = 0, por_done = 0;
  logic [7:0] remote_duty = 0, local_duty = 0, v, k, d, e, o;
  logic [15:0] measured_speed_count = 0;
  wire wr_lsb_edge, ack_q, soft_reset_q, smbalert_n_q;
  wire [7:0] wr_addr, wr_data, rd_addr, rd_data_q, fan_duty_q;
  wire [7:0] duty_cycle_setting;
  wire [15:0] target_speed_count;
  wire [1:0] fan_mode_q;
  integer seed = 32'h96BAF004, mismatches = 0, compares = 0, i;
  fmc_top #(.W(8)) i_dut (.clk, .reset, .wr_lsb_edge, .wr_addr, .wr_data,
    .rd_addr, .duty_cycle_setting, .target_speed_count, .measured_speed_count,
    .speed_valid, .remote_duty, .local_duty, .supply_flag,
    .remote_over_temp_flag, .remote_sensor_fail, .por_done, .rd_data_q,
    .ack_q, .soft_reset_q, .smbalert_n_q, .fan_duty_q, .fan_mode_q);
  fmc_host i_host (.clk, .ack_q, .rd_data_q, .wr_lsb_edge, .wr_addr,
    .wr_data, .rd_addr, .duty_cycle_setting, .target_speed_count);
  // clock
  always #10 clk = ~clk;
  // compare one result
  task automatic cmp(input logic [7:0] g, input logic [7:0] x);
    compares++;
    if (g !== x) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  // verdict and end of run
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // watchdog
  initial begin
    #200000;
    mismatches++;
    end_of_test;
  end
  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    reset <= 0;
    por_done <= 1;
    i_host.rd(8'h00, v); cmp(v, 8'hD4);
    i_host.rd(8'h01, v); cmp(v, 8'h3D);
    cmp({6'h00, fan_mode_q}, 8'h02);
    i_host.wr(8'h00, 8'hD6, k); cmp(k, 8'h01);
    for (i = 0; i < 8; i++) begin
      d = $random(seed) & 8'h7F;
      i_host.wr(8'h01, d, k); cmp(k, 8'h01);
      supply_flag <= i[0];
      remote_over_temp_flag <= i[1];
      i_host.rd(8'h01, v); cmp(v, d & 8'h60 | 8'h1D);
      e = {7'h00, !(i[0] && d[6] || i[1] && d[5])};
      cmp({7'h00, smbalert_n_q}, e);
    end
    for (i = 0; i < 4; i++) begin
      i_host.wr(8'h00, {1'h1, i[1:0], 5'h17}, k); cmp(k, 8'h01);
      remote_duty <= $random(seed);
      local_duty <= $random(seed);
      d = $random(seed);
      i_host.vals(d, 16'h1000);
      repeat (6) @(posedge clk);
      #1 cmp({6'h00, fan_mode_q}, {6'h00, i[1:0]});
      e = remote_duty > local_duty ? remote_duty : local_duty;
      e = i == 0 ? d : i == 2 ? remote_duty : e;
      if (i != 1) cmp(fan_duty_q, e);
      if (i == 1) begin
        o = fan_duty_q;
        measured_speed_count <= 16'h2000;
        speed_valid <= 1;
        @(posedge clk) speed_valid <= 0;
        repeat (4) @(posedge clk);
        #1 cmp({7'h00, fan_duty_q - o == 1 || o - fan_duty_q == 1}, 1);
      end
    end
    i_host.wr(8'h00, 8'hF6, k); cmp(k, 8'h01);
    remote_duty <= ~e;
    local_duty <= ~e;
    repeat (6) @(posedge clk);
    #1 cmp(fan_duty_q, e);
    i_host.wr(8'h01, 8'h80 | $random(seed), k); cmp(k, 8'h00);
    repeat (3) @(posedge clk);
    i_host.rd(8'h00, v); cmp(v, 8'hD4);
    i_host.rd(8'h01, v); cmp(v, 8'h3D);
    reset <= 1;
    remote_sensor_fail <= 1;
    por_done <= 0;
    repeat (2) @(posedge clk);
    reset <= 0;
    @(posedge clk) por_done <= 1;
    i_host.rd(8'h01, v); cmp(v, 8'h1D);
    end_of_test;
  end
endmodule
